// ### hw/boot_loader_params.svh
// offsets, field positions, reset values and timing counts of the boot loader
`ifndef BOOT_LOADER_PARAMS_SVH
`define BOOT_LOADER_PARAMS_SVH
`define BOOT_ROM_ADDR      32'hef000000
`define EXT_BASE_ADDR      32'h20000000
`define L1_CORE_A_ADDR     32'hffa00000
`define CORE_B_ADDR        32'hff600000
`define RSTCFG_SOFT_BIT    4
`define SYSCFG_COREB_BIT   5
`define HOLD_DEFAULT       2'h3
`define ACCESS_DEFAULT     4'hf
`define SETUP_DEFAULT      3'h4
`define GH_WIDTH_BIT       0
`define GH_WAIT_LSB        1
`define GH_HOLD_LSB        6
`define GH_RATE_LSB        8
`define GH_SIG_LSB         28
`define BOOT_SIGNATURE     4'ha
`define FLAG_ZEROFILL_BIT  0
`define FLAG_IGNORE_BIT    4
`define FLAG_FINAL_BIT     15
`define GHDR_LAST          4'h3
`define BHDR_LAST          4'h9
`define COUNT_BLOCK_BYTES  32'h00000004
`define EEP_READ_CMD       8'h03
`define EEP_START_ADDR     16'h0000
`define EEP_HDR_BITS       5'h18
`define SYS_CLK_HZ         100000000
`define SPI_HALF_500K      (`SYS_CLK_HZ / (2 * 500000))
`define SPI_HALF_1M        (`SYS_CLK_HZ / (2 * 1000000))
`define SPI_HALF_2M        (`SYS_CLK_HZ / (2 * 2000000))
`define SETTLE_CYCLES      2'h3
`endif

// ### hw/boot_loader_pkg.sv
// types shared by the boot loader
package boot_loader_pkg;
    typedef enum logic [1:0] {
        SRC_DIRECT = 2'b00,
        SRC_FLASH  = 2'b01,
        SRC_HOST   = 2'b10,
        SRC_EEPROM = 2'b11
    } boot_src_t;
    typedef enum logic [2:0] {
        L_WAIT = 3'b000, L_RUN  = 3'b001, L_GHDR = 3'b010, L_BHDR = 3'b011,
        L_BODY = 3'b100, L_FILL = 3'b101, L_HALT = 3'b110
    } ldr_state_t;
    typedef enum logic [1:0] {
        F_IDLE = 2'b00, F_SETUP = 2'b01, F_ACCESS = 2'b10, F_HOLD = 2'b11
    } flash_state_t;
    typedef enum logic [1:0] {
        E_IDLE = 2'b00, E_CMD = 2'b01, E_READ = 2'b10
    } eep_state_t;
endpackage

// ### hw/boot_stream_loader.sv
// boot source selection, stream parsing and core start sequencing
`timescale 1ns/1ps
`include "boot_loader_params.svh"
module boot_stream_loader
    import boot_loader_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  bootSourceSelect,
    input  wire logic [7:0]  resetConfigReg,
    input  wire logic [7:0]  sysConfigReg,
    output logic [31:0]      coreAPc,
    output logic             coreAAppStart,
    output logic [31:0]      coreBPc,
    output logic             coreBRun,
    output logic             bootHalted,
    output logic [1:0]       ebiuHoldCycles,
    output logic [3:0]       ebiuAccessCycles,
    output logic [2:0]       ebiuSetupCycles,
    output logic             ebiuBus16,
    output logic             flashBank0SelN,
    output logic             flashRdN,
    output logic [31:0]      flashAddr,
    input  wire logic [15:0] flashData,
    output logic             spiSck,
    output logic             spiMosi,
    output logic             spiMemorySelectPinN,
    input  wire logic        spiMiso,
    input  wire logic        spiSlaveSclk,
    input  wire logic        spiSlaveMosi,
    input  wire logic        spiSlaveSelN,
    output logic             spiSlaveMiso,
    output logic             spiSlaveMisoOe,
    output logic             memWrValid,
    output logic [31:0]      memWrAddr,
    output logic [7:0]       memWrData,
    input  wire logic        memWrReady
);
    ldr_state_t   state_q;
    boot_src_t    src_q;
    flash_state_t fState_q;
    eep_state_t   eState_q;
    logic [1:0]  selS1_q, selS2_q, settle_q;
    logic [15:0] fdS1_q, fdS2_q;
    logic [2:0]  sclkS_q, mosiS_q, selNS_q;
    logic [1:0]  misoS_q;
    logic [7:0]  srcByte_q;
    logic        srcValid_q;
    logic [31:0] ghdr_q, blkAddr_q, blkCount_q;
    logic [15:0] blkFlags_q;
    logic [3:0]  hdrIdx_q, fCnt_q;
    logic        firstBlk_q;
    logic [1:0]  rate_q;
    logic [31:0] rdAddr_q;
    logic [7:0]  div_q, half;
    logic [4:0]  eBits_q;
    logic [23:0] eTx_q;
    logic [7:0]  eRx_q, sRx_q;
    logic [2:0]  sBits_q;
    logic [31:0] fifoAddr_q [2];
    logic [7:0]  fifoData_q [2];
    logic        wrPtr_q, rdPtr_q;
    logic [1:0]  fifoCnt_q;
    logic        srcWant, byteTake, push, pop, fifoInReady, tick, eStall;
    logic        sRise, flashDone, eepDone, slaveDone;
    logic [7:0]  pushData;
    logic [31:0] lastWord;
    logic [15:0] lastFlags;

    // pin synchronisers
    always_ff @(posedge sys_clk) begin
        selS1_q <= bootSourceSelect;
        selS2_q <= selS1_q;
        fdS1_q  <= flashData;
        fdS2_q  <= fdS1_q;
        sclkS_q <= {sclkS_q[1:0], spiSlaveSclk};
        mosiS_q <= {mosiS_q[1:0], spiSlaveMosi};
        selNS_q <= {selNS_q[1:0], spiSlaveSelN};
        misoS_q <= {misoS_q[0], spiMiso};
    end

    // byte handshake between source and parser
    assign srcWant   = (state_q == L_GHDR) || (state_q == L_BHDR) || (state_q == L_BODY);
    assign lastWord  = {srcByte_q, ghdr_q[31:8]};
    assign lastFlags = {srcByte_q, blkFlags_q[15:8]};
    always_comb begin
        byteTake = 1'b0;
        push     = 1'b0;
        pushData = srcByte_q;
        if (state_q == L_GHDR || state_q == L_BHDR) begin
            byteTake = srcValid_q;
        end else if (state_q == L_BODY) begin
            byteTake = srcValid_q && (blkFlags_q[`FLAG_IGNORE_BIT] || fifoInReady);
            push     = byteTake && !blkFlags_q[`FLAG_IGNORE_BIT];
        end else if (state_q == L_FILL) begin
            push     = fifoInReady;
            pushData = 8'h00;
        end
    end

    // main boot sequencer
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q       <= L_WAIT;
            src_q         <= SRC_DIRECT;
            settle_q      <= 2'h0;
            coreAPc       <= `BOOT_ROM_ADDR;
            coreAAppStart <= 1'b0;
            ghdr_q        <= 32'h0;
            blkAddr_q     <= 32'h0;
            blkCount_q    <= 32'h0;
            blkFlags_q    <= 16'h0;
            hdrIdx_q      <= 4'h0;
            firstBlk_q    <= 1'b1;
        end else begin
            unique case (state_q)
                L_WAIT: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == `SETTLE_CYCLES) begin
                        src_q <= boot_src_t'(selS2_q);
                        if (resetConfigReg[`RSTCFG_SOFT_BIT]) begin
                            coreAPc       <= `L1_CORE_A_ADDR;
                            coreAAppStart <= 1'b1;
                            state_q       <= L_RUN;
                        end else if (boot_src_t'(selS2_q) == SRC_DIRECT) begin
                            coreAPc       <= `EXT_BASE_ADDR;
                            coreAAppStart <= 1'b1;
                            state_q       <= L_RUN;
                        end else begin
                            state_q <= L_GHDR;
                        end
                    end
                end
                L_RUN: state_q <= L_RUN;
                L_HALT: state_q <= L_HALT;
                L_GHDR: if (byteTake) begin
                    ghdr_q   <= lastWord;
                    hdrIdx_q <= hdrIdx_q + 4'h1;
                    if (hdrIdx_q == `GHDR_LAST) begin
                        hdrIdx_q <= 4'h0;
                        state_q  <= (srcByte_q[7:4] == `BOOT_SIGNATURE) ? L_BHDR : L_HALT;
                    end
                end
                L_BHDR: if (byteTake) begin
                    hdrIdx_q <= hdrIdx_q + 4'h1;
                    if (hdrIdx_q < 4'h4) begin
                        blkAddr_q <= {srcByte_q, blkAddr_q[31:8]};
                    end else if (hdrIdx_q < 4'h8) begin
                        blkCount_q <= {srcByte_q, blkCount_q[31:8]};
                    end else begin
                        blkFlags_q <= lastFlags;
                    end
                    if (hdrIdx_q == `BHDR_LAST) begin
                        hdrIdx_q   <= 4'h0;
                        firstBlk_q <= 1'b0;
                        if (firstBlk_q && blkCount_q != `COUNT_BLOCK_BYTES) begin
                            state_q <= L_HALT;
                        end else if (blkCount_q == 32'h0) begin
                            state_q <= lastFlags[`FLAG_FINAL_BIT] ? L_RUN : L_BHDR;
                            if (lastFlags[`FLAG_FINAL_BIT]) begin
                                coreAPc       <= `L1_CORE_A_ADDR;
                                coreAAppStart <= 1'b1;
                            end
                        end else if (lastFlags[`FLAG_ZEROFILL_BIT] &&
                                     !lastFlags[`FLAG_IGNORE_BIT]) begin
                            state_q <= L_FILL;
                        end else begin
                            state_q <= L_BODY;
                        end
                    end
                end
                L_BODY, L_FILL: if (byteTake || push) begin
                    blkAddr_q  <= blkAddr_q + 32'h1;
                    blkCount_q <= blkCount_q - 32'h1;
                    if (blkCount_q == 32'h1) begin
                        state_q <= blkFlags_q[`FLAG_FINAL_BIT] ? L_RUN : L_BHDR;
                        if (blkFlags_q[`FLAG_FINAL_BIT]) begin
                            coreAPc       <= `L1_CORE_A_ADDR;
                            coreAAppStart <= 1'b1;
                        end
                    end
                end
                default: state_q <= L_HALT;
            endcase
        end
    end
    assign bootHalted = (state_q == L_HALT);

    // core B held until core A application starts with system config bit 5 clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            coreBRun <= 1'b0;
            coreBPc  <= `CORE_B_ADDR;
        end else if (coreAAppStart && !sysConfigReg[`SYSCFG_COREB_BIT]) begin
            coreBRun <= 1'b1;
        end
    end

    // external memory timing, slowest until the header says otherwise
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ebiuHoldCycles   <= `HOLD_DEFAULT;
            ebiuAccessCycles <= `ACCESS_DEFAULT;
            ebiuSetupCycles  <= `SETUP_DEFAULT;
            ebiuBus16        <= 1'b0;
            rate_q           <= 2'h0;
        end else if (state_q == L_WAIT) begin
            ebiuBus16 <= (boot_src_t'(selS2_q) == SRC_DIRECT);
        end else if (state_q == L_GHDR && byteTake && hdrIdx_q == `GHDR_LAST &&
                     srcByte_q[7:4] == `BOOT_SIGNATURE) begin
            rate_q <= lastWord[`GH_RATE_LSB +: 2];
            if (src_q == SRC_FLASH) begin
                ebiuBus16        <= lastWord[`GH_WIDTH_BIT];
                ebiuAccessCycles <= lastWord[`GH_WAIT_LSB +: 4];
                ebiuHoldCycles   <= lastWord[`GH_HOLD_LSB +: 2];
            end
        end
    end

    // flash reader on bank 0, one byte per access
    assign flashDone = (fState_q == F_HOLD) && (fCnt_q == 4'h0);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fState_q       <= F_IDLE;
            fCnt_q         <= 4'h0;
            flashBank0SelN <= 1'b1;
            flashRdN       <= 1'b1;
            rdAddr_q       <= 32'h0;
        end else begin
            unique case (fState_q)
                F_IDLE: if (src_q == SRC_FLASH && srcWant && !srcValid_q) begin
                    fState_q       <= F_SETUP;
                    fCnt_q         <= {1'b0, ebiuSetupCycles};
                    flashBank0SelN <= 1'b0;
                end
                F_SETUP: if (fCnt_q == 4'h0) begin
                    fState_q <= F_ACCESS;
                    fCnt_q   <= ebiuAccessCycles;
                    flashRdN <= 1'b0;
                end else begin
                    fCnt_q <= fCnt_q - 4'h1;
                end
                F_ACCESS: if (fCnt_q == 4'h0) begin
                    fState_q <= F_HOLD;
                    fCnt_q   <= {2'h0, ebiuHoldCycles};
                    flashRdN <= 1'b1;
                end else begin
                    fCnt_q <= fCnt_q - 4'h1;
                end
                F_HOLD: if (fCnt_q == 4'h0) begin
                    fState_q       <= F_IDLE;
                    flashBank0SelN <= 1'b1;
                    rdAddr_q       <= rdAddr_q + 32'h1;
                end else begin
                    fCnt_q <= fCnt_q - 4'h1;
                end
            endcase
        end
    end
    assign flashAddr = rdAddr_q;

    // serial clock divider for the EEPROM master
    always_comb begin
        unique case (rate_q)
            2'h1:    half = 8'(`SPI_HALF_1M);
            2'h2:    half = 8'(`SPI_HALF_2M);
            default: half = 8'(`SPI_HALF_500K);
        endcase
    end
    assign eStall = (eState_q == E_READ) && srcValid_q;
    assign tick   = (div_q == half - 8'h1) && !eStall;
    always_ff @(posedge sys_clk) begin
        if (reset || eState_q == E_IDLE || tick) begin
            div_q <= 8'h0;
        end else if (!eStall) begin
            div_q <= div_q + 8'h1;
        end
    end

    // EEPROM master: command and address, then continuous read
    assign eepDone = tick && spiSck == 1'b0 && eState_q == E_READ && eBits_q == 5'h7;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            eState_q            <= E_IDLE;
            spiSck              <= 1'b0;
            spiMemorySelectPinN <= 1'b1;
            eBits_q             <= 5'h0;
            eTx_q               <= 24'h0;
            eRx_q               <= 8'h0;
        end else begin
            unique case (eState_q)
                E_IDLE: if (src_q == SRC_EEPROM && state_q == L_GHDR) begin
                    eState_q            <= E_CMD;
                    spiMemorySelectPinN <= 1'b0;
                    eTx_q               <= {`EEP_READ_CMD, `EEP_START_ADDR};
                end
                E_CMD: if (tick) begin
                    spiSck <= !spiSck;
                    if (!spiSck) begin
                        eBits_q <= eBits_q + 5'h1;
                    end else if (eBits_q == `EEP_HDR_BITS) begin
                        eState_q <= E_READ;
                        eBits_q  <= 5'h0;
                    end else begin
                        eTx_q <= {eTx_q[22:0], 1'b0};
                    end
                end
                E_READ: begin
                    if (tick) begin
                        spiSck <= !spiSck;
                        if (!spiSck) begin
                            eRx_q   <= {eRx_q[6:0], misoS_q[1]};
                            eBits_q <= (eBits_q == 5'h7) ? 5'h0 : eBits_q + 5'h1;
                        end
                    end
                    if (!srcWant && state_q != L_FILL) begin
                        eState_q            <= E_IDLE;
                        spiMemorySelectPinN <= 1'b1;
                        spiSck              <= 1'b0;
                    end
                end
                default: eState_q <= E_IDLE;
            endcase
        end
    end
    assign spiMosi = eTx_q[23];

    // SPI slave for host boot, host clock sampled by sys_clk
    assign sRise     = sclkS_q[1] && !sclkS_q[2] && !selNS_q[1];
    assign slaveDone = sRise && sBits_q == 3'h7 && src_q == SRC_HOST;
    always_ff @(posedge sys_clk) begin
        if (reset || selNS_q[1]) begin
            sBits_q <= 3'h0;
            sRx_q   <= 8'h0;
        end else if (sRise) begin
            sRx_q   <= {sRx_q[6:0], mosiS_q[1]};
            sBits_q <= sBits_q + 3'h1;
        end
    end
    assign spiSlaveMiso   = 1'b0;
    assign spiSlaveMisoOe = (src_q == SRC_HOST) && !selNS_q[1] && srcWant;

    // one byte holding stage from whichever source is active
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            srcValid_q <= 1'b0;
            srcByte_q  <= 8'h0;
        end else if (flashDone) begin
            srcValid_q <= 1'b1;
            srcByte_q  <= (ebiuBus16 && rdAddr_q[0]) ? fdS2_q[15:8] : fdS2_q[7:0];
        end else if (eepDone) begin
            srcValid_q <= 1'b1;
            srcByte_q  <= {eRx_q[6:0], misoS_q[1]};
        end else if (slaveDone && srcWant) begin
            srcValid_q <= 1'b1; // host cannot be stalled, late byte overwrites
            srcByte_q  <= {sRx_q[6:0], mosiS_q[1]};
        end else if (byteTake) begin
            srcValid_q <= 1'b0;
        end
    end

    // two-entry write buffer toward memory
    assign fifoInReady = (fifoCnt_q != 2'h2);
    assign memWrValid  = (fifoCnt_q != 2'h0);
    assign pop         = memWrValid && memWrReady;
    assign memWrAddr   = fifoAddr_q[rdPtr_q];
    assign memWrData   = fifoData_q[rdPtr_q];
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPtr_q   <= 1'b0;
            rdPtr_q   <= 1'b0;
            fifoCnt_q <= 2'h0;
        end else begin
            if (push) begin
                fifoAddr_q[wrPtr_q] <= blkAddr_q;
                fifoData_q[wrPtr_q] <= pushData;
                wrPtr_q             <= !wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= !rdPtr_q;
            end
            fifoCnt_q <= fifoCnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // checks
    coreBOrder_a: assert property (@(posedge sys_clk) disable iff (reset)
        coreBRun |-> coreAAppStart && coreBPc == `CORE_B_ADDR)
        else $error("core B runs before core A application");
    haltNoStart_a: assert property (@(posedge sys_clk) disable iff (reset)
        bootHalted |-> !coreAAppStart && !push)
        else $error("halted boot started a core or wrote memory");
    romFetch_a: assert property (@(posedge sys_clk) disable iff (reset)
        !coreAAppStart |-> coreAPc == `BOOT_ROM_ADDR && !coreBRun)
        else $error("boot fetch address wrong while loading");
    directStart_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(coreAAppStart) && src_q == SRC_DIRECT && !resetConfigReg[`RSTCFG_SOFT_BIT]
        |-> coreAPc == `EXT_BASE_ADDR && ebiuBus16)
        else $error("direct mode start address wrong");
    loadedStart_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(coreAAppStart) && src_q != SRC_DIRECT |-> coreAPc == `L1_CORE_A_ADDR)
        else $error("loaded application start address wrong");
    slowTiming_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == L_GHDR |-> ebiuAccessCycles == 4'hf && ebiuHoldCycles == 2'h3
        && ebiuSetupCycles == 3'h4)
        else $error("memory timing not slowest before header");
    chipSel_a: assert property (@(posedge sys_clk) disable iff (reset)
        !spiMemorySelectPinN |-> src_q == SRC_EEPROM)
        else $error("EEPROM select outside EEPROM boot");
    ignoreSkip_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == L_BODY && blkFlags_q[`FLAG_IGNORE_BIT] |-> !push)
        else $error("ignored block written to memory");
    fillZero_a: assert property (@(posedge sys_clk) disable iff (reset)
        push && state_q == L_FILL |=> fifoData_q[$past(wrPtr_q)] == 8'h00)
        else $error("zero fill wrote non-zero data");
    badSig_a: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == L_GHDR && byteTake && hdrIdx_q == `GHDR_LAST
        && srcByte_q[7:4] != `BOOT_SIGNATURE |=> bootHalted [*4])
        else $error("bad signature not halted");
    bankSel_a: assert property (@(posedge sys_clk) disable iff (reset)
        !flashRdN |-> !flashBank0SelN && src_q == SRC_FLASH)
        else $error("flash read outside bank 0 cycle");
    bootDone_c: cover property (@(posedge sys_clk) disable iff (reset)
        $rose(coreAAppStart) && src_q == SRC_FLASH);
    halt_c: cover property (@(posedge sys_clk) disable iff (reset) $rose(bootHalted));
    fill_c: cover property (@(posedge sys_clk) disable iff (reset) state_q == L_FILL && push);
    eeprom_c: cover property (@(posedge sys_clk) disable iff (reset) eepDone);
endmodule

// ### verif/flash_model.sv
// far-side boot memory: byte-wide flash and serial EEPROM sharing one stream
`timescale 1ns/1ps
module flash_model (
    input  wire logic        sys_clk,
    input  wire logic        selN,
    input  wire logic [31:0] addr,
    output logic      [15:0] data,
    input  wire logic        sck,
    input  wire logic        csN,
    input  wire logic        mosi,
    output logic             miso
);
    logic [7:0]  mem [0:63];
    logic [23:0] cmd = 24'h0;
    int          n = 0;
    initial data = 16'h0;
    initial miso = 1'b0;
    // serial EEPROM: command bits in on rising sck, stream out on falling sck
    always @(negedge csN) n = 0;
    always @(posedge sck) if (!csN) begin
        if (n < 24) cmd = {cmd[22:0], mosi};
        n++;
    end
    // released line scrambled so a late sample shows up
    always @(negedge sck or posedge csN) begin
        if (csN) miso <= ~miso;
        else if (n >= 24) miso <= mem[6'((n - 24) / 8)][3'(7 - (n - 24) % 8)];
    end
    // addressed byte on the low lane while selected, scrambled when released
    always @(posedge sys_clk) begin
        data <= selN ? ~data : {8'h00, mem[addr[5:0]]};
    end
endmodule

// ### verif/boot_stream_loader_tb.sv
// self-checking bench: flash load, bad signature, soft reset, direct mode, EEPROM and host boot
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module boot_stream_loader_tb;
    import boot_loader_pkg::*;
    logic        sys_clk = 0, reset = 1, coreAAppStart, coreBRun, bootHalted, ebiuBus16;
    logic [1:0]  bootSourceSelect = 2'h1, ebiuHoldCycles;
    logic [7:0]  resetConfigReg = 8'h00, sysConfigReg = 8'h20, memWrData;
    logic [31:0] coreAPc, coreBPc, flashAddr, memWrAddr;
    logic [3:0]  ebiuAccessCycles, wt;
    logic [2:0]  ebiuSetupCycles;
    logic [15:0] flashData;
    logic        flashBank0SelN, flashRdN, spiSck, spiMosi, spiMemorySelectPinN;
    logic        spiMiso, spiSlaveSclk = 0, spiSlaveMosi = 0, spiSlaveSelN = 1;
    logic        spiSlaveMiso, spiSlaveMisoOe, memWrValid, memWrReady = 0;
    logic [1:0]  hd;
    logic [39:0] expq [$];
    int          miscompares = 0, tests_run = 0, p;
    boot_stream_loader i_boot_stream_loader (.*);
    flash_model i_flash_model (.sys_clk(sys_clk), .selN(flashBank0SelN),
        .addr(flashAddr), .data(flashData), .sck(spiSck), .csN(spiMemorySelectPinN),
        .mosi(spiMosi), .miso(spiMiso));
    initial forever #5 sys_clk = ~sys_clk;
    // random receiver stalls, every accepted write checked in order
    always @(negedge sys_clk) memWrReady <= 1'($urandom);
    always @(posedge sys_clk) if (memWrValid && memWrReady) begin
        `CHK({memWrAddr, memWrData}, expq.size() ? expq.pop_front() : 40'hx)
    end
    function automatic logic [31:0] gh(logic [3:0] s, logic [3:0] w, logic [1:0] h);
        return {s, 20'h0, h, 1'b0, w, 1'b0};
    endfunction
    task automatic put(logic [31:0] v, int n);
        for (int k = 0; k < n; k++) i_flash_model.mem[p++] = v[8*k+:8];
    endtask
    // header, body and expected writes of one block
    task automatic blk(logic [31:0] a, logic [31:0] c, logic [15:0] f);
        logic [7:0] d;
        put(a, 4); put(c, 4); put(32'(f), 2);
        for (int i = 0; i < c; i++) begin
            d = f[0] ? 8'h00 : 8'($urandom);
            if (!f[0]) put(32'(d), 1);
            if (!f[4]) expq.push_back({a + 32'(i), d});
        end
    endtask
    // global header, count block, then blocks; short streams keep serial boots quick
    task automatic stream(logic [31:0] h, bit full);
        p = 0;
        put(h, 4);
        blk($urandom, 4, 16'h0010);
        if (full) begin
            blk($urandom, 3, 16'h0000);
            blk($urandom, 2, 16'h0001);
        end
        blk($urandom, 1, 16'h8000);
    endtask
    // SPI host: 160 ns clock, MSB first, one select for the whole stream
    task automatic host(int n);
        spiSlaveSelN = 0;
        for (int k = 0; k < 8 * n; k++) begin
            spiSlaveMosi = i_flash_model.mem[k / 8][7 - k % 8];
            repeat (8) @(negedge sys_clk);
            if (k == 0) `CHK({spiSlaveMisoOe, spiSlaveMiso}, 2'b10)
            spiSlaveSclk = 1;
            repeat (8) @(negedge sys_clk);
            spiSlaveSclk = 0;
        end
        spiSlaveSelN = 1;
    endtask
    // bounded wait until the write buffer has drained
    task automatic drain();
        for (int i = 0; memWrValid; i++) begin
            if (i > 100) begin miscompares++; report_and_stop(); end
            @(negedge sys_clk);
        end
    endtask
    task automatic boot(logic [1:0] s, logic [7:0] r);
        @(negedge sys_clk);
        reset = 1; bootSourceSelect = s; resetConfigReg = r; sysConfigReg = 8'h20;
        repeat (3) @(negedge sys_clk);
        reset = 0;
        if (s == 2'h2) fork host(p); join_none
        repeat (3) @(negedge sys_clk);
        `CHK({coreAPc, coreBRun}, {32'hef000000, 1'b0})
        for (int i = 0; !(coreAAppStart || bootHalted); i++) begin
            if (i > 30000) begin miscompares++; report_and_stop(); end
            @(negedge sys_clk);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hdc1e));
        wt = 4'($urandom); hd = 2'($urandom); p = 0;
        stream(gh(4'ha, wt, hd) | 32'h07fff820, 1'b1);
        boot(2'h1, 8'h00);
        drain();
        `CHK({coreAPc, coreAAppStart, expq.size()}, {32'hffa00000, 1'b1, 32'h0})
        `CHK({ebiuAccessCycles, ebiuHoldCycles, ebiuBus16}, {wt, hd, 1'b0})
        `CHK(coreBRun, 1'b0)
        sysConfigReg = 8'h00;
        repeat (3) @(negedge sys_clk);
        `CHK({coreBRun, coreBPc}, {1'b1, 32'hff600000})
        p = 0;
        put(gh(4'h0, wt, hd), 4);
        boot(2'h1, 8'h00);
        `CHK({bootHalted, coreAAppStart}, 2'b10)
        boot(2'h1, 8'h10);
        `CHK({coreAPc, coreAAppStart}, {32'hffa00000, 1'b1})
        boot(2'h0, 8'h00);
        `CHK({coreAPc, ebiuBus16}, {32'h20000000, 1'b1})
        `CHK({ebiuHoldCycles, ebiuAccessCycles, ebiuSetupCycles}, {2'h3, 4'hf, 3'h4})
        stream(gh(4'ha, wt, hd) | 32'h00000200, 1'b0);
        boot(2'h3, 8'h00);
        drain();
        `CHK({coreAPc, expq.size(), spiMemorySelectPinN}, {32'hffa00000, 32'h0, 1'b1})
        `CHK(i_flash_model.cmd, 24'h030000)
        stream(gh(4'ha, wt, hd), 1'b0);
        boot(2'h2, 8'h00);
        drain();
        `CHK({coreAPc, expq.size()}, {32'hffa00000, 32'h0})
        report_and_stop();
    end
endmodule
